// ---- psm_pkg.sv ----
package psm_pkg;

  typedef enum logic [2:0] {
    PSM_NO_POWER,
    PSM_STANDBY_ONLY,
    PSM_ON,
    PSM_SHALLOW_SLEEP,
    PSM_SLEEP,
    PSM_DEEP_SLEEP
  } psm_state_e;

  typedef enum logic [3:0] {
    PSM_TL_NONE,
    PSM_TL_SHALLOW_ENTRY,
    PSM_TL_SHALLOW_EXIT,
    PSM_TL_SLEEP_ENTRY,
    PSM_TL_SLEEP_EXIT,
    PSM_TL_DEEP_ENTRY,
    PSM_TL_DEEP_EXIT,
    PSM_TL_COLD_OFF
  } psm_task_e;

  // Host sideband pins, all raw and asynchronous
  typedef struct packed {
    logic shallow_sleep_req_n;
    logic sleep_req_n;
    logic deep_sleep_req_n;
    logic suspend_powerdown_ack;
    logic platform_reset_n;
  } psm_host_s;

  localparam int PSM_SYNC_STAGES    = 2;
  localparam int PSM_BTN_FAULT_TICKS = 4000;
  localparam int PSM_BTN_CNT_W      = 16;

endpackage : psm_pkg

// ---- psm_sync.sv ----
module psm_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             sys_clk_i,
  input  wire logic             reset_i,
  input  wire logic [WIDTH-1:0] async_i,
  input  wire logic [WIDTH-1:0] rst_val_i,
  output logic      [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // Flops reset to zero; the rst_val_i XOR makes sync_o reset to rst_val_i
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_i ^ rst_val_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q ^ rst_val_i;
endmodule : psm_sync

// ---- soc_power_state_machine.sv ----
// Overview of operation
// - Supply loss: reset to no-power state
// - Thermal critical: forced shutdown, no task list
// - Other critical: cold-off list then standby
// - Platform reset low in on, shallow: serial interface reset
// - Shallow request low in on: enter shallow
// - Button held in on: relay to host
// - Serial interfaces stay on in shallow sleep
// - Serial interfaces off in sleep, deep sleep
// - Standby states: retain registers, thermal off
// - Enable pin low in shallow: cold-off
// - Shallow request high: exit list, go on
// - Sleep request low in shallow: enter sleep
// - Sleep request high: exit to shallow/on
// - Deep request low in sleep: enter deep
// - Ack in deep sleep: cold-off to standby
// - Deep request high: exit to sleep
// - Button in shallow sleep: wake relay
// - Comparators, interrupts active in shallow, sleep
// - Power-save mode allowed in standby states
module soc_power_state_machine
  import psm_pkg::*;
#(
  parameter int BTN_FAULT_TICKS = psm_pkg::PSM_BTN_FAULT_TICKS
) (
  input  wire logic                  sys_clk_i,
  input  wire logic                  reset_i,
  input  wire psm_pkg::psm_host_s    host_i,
  input  wire logic                  power_button_in_n_i,
  input  wire logic                  chip_enable_pin_i,
  input  wire logic                  enable_pin_mode_i,
  input  wire logic                  shallow_sleep_used_i,
  input  wire logic                  supply_valid_i,
  input  wire logic                  start_i,
  input  wire logic                  thermal_critical_i,
  input  wire logic                  other_critical_i,
  input  wire logic                  task_done_i,
  output psm_pkg::psm_state_e        state_o,
  output logic                       task_start_o,
  output psm_pkg::psm_task_e         task_list_o,
  output logic                       rail_force_off_o,
  output logic                       logic_reset_o,
  output logic                       serial_if_reset_o,
  output logic                       serial_if_enable_o,
  output logic                       thermal_mon_enable_o,
  output logic                       comparators_active_o,
  output logic                       power_save_allowed_o,
  output logic                       power_button_to_host_n_o,
  output logic                       button_fault_o
);
  import psm_pkg::*;

  // Idle pin levels, so no request or ack is seen while the flops fill
  localparam logic [4:0] HOST_RST = 5'h1d;
  localparam logic [1:0] PIN_RST  = 2'h3;

  psm_host_s host_s;
  logic [1:0] pin_s;
  logic       btn_n_s;
  logic       en_pin_s;

  psm_sync #(.WIDTH(5)) u_host_sync (
    .sys_clk_i (sys_clk_i),
    .reset_i   (reset_i),
    .async_i   (host_i),
    .rst_val_i (HOST_RST),
    .sync_o    (host_s)
  );

  psm_sync #(.WIDTH(2)) u_pin_sync (
    .sys_clk_i (sys_clk_i),
    .reset_i   (reset_i),
    .async_i   ({power_button_in_n_i, chip_enable_pin_i}),
    .rst_val_i (PIN_RST),
    .sync_o    (pin_s)
  );
  assign btn_n_s  = pin_s[1];
  assign en_pin_s = pin_s[0];

  psm_state_e state_q, state_d;
  psm_task_e  task_q, task_d;
  logic       busy_q;
  psm_state_e dest_q;
  logic       force_q;
  logic       srst_q;
  logic [PSM_BTN_CNT_W-1:0] btn_cnt_q;
  logic       fault_q;
  logic       relay_q;
  logic       go;
  psm_state_e dest_d;

  // Button fault timer; released button clears it
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      btn_cnt_q <= '0;
      fault_q   <= 1'b0;
    end else if (btn_n_s) begin
      btn_cnt_q <= '0;
      fault_q   <= 1'b0;
    end else if (btn_cnt_q < PSM_BTN_CNT_W'(BTN_FAULT_TICKS)) begin
      btn_cnt_q <= btn_cnt_q + 1'b1;
    end else begin
      fault_q <= 1'b1;
    end
  end

  // Button relayed in any powered state, fault or not
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      relay_q <= 1'b1;
    end else begin
      relay_q <= (state_q == PSM_NO_POWER) ? 1'b1 : btn_n_s;
    end
  end

  // Transition select; supply loss and thermal critical first, other critical once no list runs
  always_comb begin
    state_d = state_q;
    task_d  = PSM_TL_NONE;
    dest_d  = state_q;
    go      = 1'b0;
    if (state_q != PSM_NO_POWER && state_q != PSM_STANDBY_ONLY) begin
      if (!supply_valid_i) begin
        state_d = PSM_NO_POWER;
      end else if (thermal_critical_i) begin
        state_d = PSM_STANDBY_ONLY;
      end else if (busy_q) begin
        state_d = state_q;
      end else if (other_critical_i) begin
        go = 1'b1;
        task_d = PSM_TL_COLD_OFF;
        dest_d = PSM_STANDBY_ONLY;
      end else begin
        case (state_q)
          PSM_ON: begin
            if (!host_s.shallow_sleep_req_n) begin
              go = 1'b1;
              task_d = PSM_TL_SHALLOW_ENTRY;
              dest_d = PSM_SHALLOW_SLEEP;
            end
          end
          PSM_SHALLOW_SLEEP: begin
            if (enable_pin_mode_i && !en_pin_s) begin
              go = 1'b1;
              task_d = PSM_TL_COLD_OFF;
              dest_d = PSM_STANDBY_ONLY;
            end else if (!host_s.sleep_req_n) begin
              go = 1'b1;
              task_d = PSM_TL_SLEEP_ENTRY;
              dest_d = PSM_SLEEP;
            end else if (host_s.shallow_sleep_req_n) begin
              go = 1'b1;
              task_d = PSM_TL_SHALLOW_EXIT;
              dest_d = PSM_ON;
            end
          end
          PSM_SLEEP: begin
            if (!host_s.deep_sleep_req_n) begin
              go = 1'b1;
              task_d = PSM_TL_DEEP_ENTRY;
              dest_d = PSM_DEEP_SLEEP;
            end else if (host_s.sleep_req_n) begin
              go = 1'b1;
              task_d = PSM_TL_SLEEP_EXIT;
              dest_d = shallow_sleep_used_i ? PSM_SHALLOW_SLEEP : PSM_ON;
            end
          end
          PSM_DEEP_SLEEP: begin
            if (host_s.suspend_powerdown_ack) begin
              go = 1'b1;
              task_d = PSM_TL_COLD_OFF;
              dest_d = PSM_STANDBY_ONLY;
            end else if (host_s.deep_sleep_req_n) begin
              go = 1'b1;
              task_d = PSM_TL_DEEP_EXIT;
              dest_d = PSM_SLEEP;
            end
          end
          default: state_d = state_q;
        endcase
      end
      if (busy_q && task_done_i && !thermal_critical_i && supply_valid_i) begin
        state_d = dest_q;
      end
    end else if (state_q == PSM_NO_POWER) begin
      if (supply_valid_i) state_d = PSM_STANDBY_ONLY;
    end else begin
      if (!supply_valid_i) begin
        state_d = PSM_NO_POWER;
      end else if (start_i) begin
        state_d = PSM_ON;
      end
    end
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_q <= PSM_NO_POWER;
    end else begin
      state_q <= state_d;
    end
  end

  // Task list runs; state moves when list completes, or at once on supply loss or thermal critical
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      busy_q <= 1'b0;
      task_q <= PSM_TL_NONE;
      dest_q <= PSM_NO_POWER;
    end else if (!supply_valid_i || thermal_critical_i) begin
      busy_q <= 1'b0;
      task_q <= PSM_TL_NONE;
    end else if (go) begin
      busy_q <= 1'b1;
      task_q <= task_d;
      dest_q <= dest_d;
    end else if (busy_q && task_done_i) begin
      busy_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      force_q <= 1'b0;
      srst_q  <= 1'b0;
    end else begin
      force_q <= supply_valid_i && thermal_critical_i && state_q != PSM_NO_POWER;
      // Low level of platform reset in on or shallow sleep holds interfaces in reset
      srst_q  <= !host_s.platform_reset_n &&
                 (state_q == PSM_ON || state_q == PSM_SHALLOW_SLEEP);
    end
  end

  logic serial_on;
  logic standby;
  assign serial_on = state_q == PSM_ON || state_q == PSM_SHALLOW_SLEEP;
  assign standby   = state_q == PSM_SHALLOW_SLEEP || state_q == PSM_SLEEP ||
                     state_q == PSM_DEEP_SLEEP;

  assign state_o                  = state_q;
  assign task_start_o             = go;
  assign task_list_o              = task_q;
  assign rail_force_off_o         = force_q;
  assign logic_reset_o            = !supply_valid_i && state_q != PSM_NO_POWER;
  assign serial_if_reset_o        = srst_q;
  assign serial_if_enable_o       = serial_on;
  assign thermal_mon_enable_o     = state_q == PSM_ON;
  assign comparators_active_o     = state_q != PSM_NO_POWER;
  assign power_save_allowed_o     = standby;
  assign power_button_to_host_n_o = relay_q;
  assign button_fault_o           = fault_q;

  a_supply_loss: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    !supply_valid_i |=> state_q == PSM_NO_POWER)
    else $error("supply loss did not reach no-power");

  a_thermal_off: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (supply_valid_i && thermal_critical_i && state_q inside {PSM_ON, PSM_SLEEP})
      |=> state_q == PSM_STANDBY_ONLY && !busy_q)
    else $error("thermal critical did not force standby");

  a_serial_off: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    state_q inside {PSM_SLEEP, PSM_DEEP_SLEEP} |-> !serial_if_enable_o)
    else $error("serial interface on in sleep");

  a_serial_on: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    state_q == PSM_SHALLOW_SLEEP |-> serial_if_enable_o)
    else $error("serial interface off in shallow sleep");

  a_thermal_mon: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    standby |-> !thermal_mon_enable_o)
    else $error("thermal monitor on in standby");

  sequence s_shallow_go;
    state_q == PSM_ON && !busy_q && go && task_d == PSM_TL_SHALLOW_ENTRY;
  endsequence
  sequence s_shallow_done;
    busy_q && task_q == PSM_TL_SHALLOW_ENTRY && task_done_i && supply_valid_i && !thermal_critical_i;
  endsequence
  a_shallow_entry: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    s_shallow_go |=> busy_q && task_q == PSM_TL_SHALLOW_ENTRY)
    else $error("shallow entry list not started");

  a_shallow_done: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    s_shallow_done |=> state_q == PSM_SHALLOW_SLEEP)
    else $error("shallow entry did not complete");

  a_button_relay: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (state_q == PSM_ON && !btn_n_s) |=> !power_button_to_host_n_o)
    else $error("button not relayed");

  a_fault_timer: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    btn_n_s |=> !button_fault_o && btn_cnt_q == '0)
    else $error("fault timer not cleared on release");

  a_ack_cold_off: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (state_q == PSM_DEEP_SLEEP && !busy_q && supply_valid_i && !thermal_critical_i &&
     host_s.suspend_powerdown_ack) |=> busy_q && task_q == PSM_TL_COLD_OFF)
    else $error("ack did not start cold-off");

  a_warm_reset: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (!host_s.platform_reset_n && state_q == PSM_ON) |=> serial_if_reset_o)
    else $error("platform reset did not reset interfaces");

endmodule : soc_power_state_machine

// ---- psm_host_model.sv ----
module psm_host_model (
  input  wire logic                sys_clk_i,
  input  wire logic                reset_i,
  input  wire logic [2:0]          goal_i,
  input  wire logic                prst_n_i,
  input  wire psm_pkg::psm_state_e state_i,
  output psm_pkg::psm_host_s       host_o
);
  timeunit 1ns;
  timeprecision 1ns;
  import psm_pkg::*;
  localparam psm_state_e AT_LVL [5] = '{PSM_ON, PSM_SHALLOW_SLEEP, PSM_SLEEP, PSM_DEEP_SLEEP, PSM_STANDBY_ONLY};
  logic [2:0] lvl_q;
  // Deeper one pin per step, after the device settled; waking may raise several pins at once
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      lvl_q <= 3'h0;
    end else if (state_i == AT_LVL[lvl_q] && goal_i != lvl_q) begin
      lvl_q <= (goal_i > lvl_q) ? lvl_q + 3'h1 : goal_i;
    end
  end
  // Struct order: shallow, sleep, deep, ack, platform reset
  assign host_o = {lvl_q < 3'h1, lvl_q < 3'h2, lvl_q < 3'h3, lvl_q == 3'h4, prst_n_i};
endmodule : psm_host_model

// ---- soc_power_state_machine_tb_top.sv ----
module soc_power_state_machine_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import psm_pkg::*;
  logic       sys_clk_i = 1'b0, reset_i = 1'b1, power_button_in_n_i = 1'b1, chip_enable_pin_i = 1'b1;
  logic       enable_pin_mode_i = 1'b0, supply_valid_i = 1'b1, start_i = 1'b1, thermal_critical_i = 1'b0;
  logic       other_critical_i = 1'b0, task_done_i = 1'b0, prst_n = 1'b1, shallow_sleep_used_i = 1'b1;
  logic [2:0] goal = 3'h0;
  psm_host_s  host_i;
  psm_state_e state_o;
  psm_task_e  task_list_o, exp_q[$];
  logic       task_start_o, rail_force_off_o, logic_reset_o, serial_if_reset_o, serial_if_enable_o;
  logic       thermal_mon_enable_o, comparators_active_o, power_save_allowed_o, power_button_to_host_n_o;
  logic       button_fault_o;
  int         n_errors = 0, tests_run = 0, seed = 32'hf0f6;

  initial forever #50 sys_clk_i = ~sys_clk_i;

  soc_power_state_machine #(.BTN_FAULT_TICKS(8)) dut (
    .sys_clk_i, .reset_i, .host_i, .power_button_in_n_i, .chip_enable_pin_i, .enable_pin_mode_i,
    .shallow_sleep_used_i, .supply_valid_i, .start_i, .thermal_critical_i, .other_critical_i,
    .task_done_i, .state_o, .task_start_o, .task_list_o, .rail_force_off_o, .logic_reset_o,
    .serial_if_reset_o, .serial_if_enable_o, .thermal_mon_enable_o, .comparators_active_o,
    .power_save_allowed_o, .power_button_to_host_n_o, .button_fault_o);

  psm_host_model host (.sys_clk_i, .reset_i, .goal_i(goal), .prst_n_i(prst_n), .state_i(state_o), .host_o(host_i));

  task automatic give_verdict();
    if (n_errors == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : give_verdict

  task automatic note(input logic [7:0] a, input logic [7:0] e);
    tests_run++;
    if (a !== e) begin
      n_errors++;
      $display("mismatch at %0t: got %h exp %h", $time, a, e);
    end
  endtask : note

  task automatic chk_bit(input logic a, input logic e);
    note({7'h0, a}, {7'h0, e});
  endtask : chk_bit

  task automatic chk_state(input psm_state_e a, input psm_state_e e);
    note({5'h0, a}, {5'h0, e});
  endtask : chk_state

  task automatic chk_task(input psm_task_e a, input psm_task_e e);
    note({4'h0, a}, {4'h0, e});
  endtask : chk_task

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask : cyc

  task automatic wait_state(input psm_state_e s);
    for (int i = 0; i < 300 && state_o !== s; i++) cyc(1);
    chk_state(state_o, s);
    if (state_o !== s) give_verdict();
  endtask : wait_state

  task automatic go(input logic [2:0] g, input psm_task_e t, input psm_state_e s);
    exp_q.push_back(t);
    goal = g;
    wait_state(s);
  endtask : go

  task automatic boot();
    cyc(1);
    reset_i = 1'b1;
    goal = 3'h0;
    start_i = 1'b1;
    cyc(20);
    chk_bit(power_button_to_host_n_o, 1'b1);
    reset_i = 1'b0;
    wait_state(PSM_ON);
    start_i = 1'b0;
  endtask : boot

  // Executor answers each launch after a random wait; unexpected launches compare against none
  always @(negedge sys_clk_i) begin
    if (task_start_o === 1'b1) begin
      cyc(1);
      chk_task(task_list_o, exp_q.size() > 0 ? exp_q.pop_front() : PSM_TL_NONE);
      repeat ($unsigned($random(seed)) % 4) @(posedge sys_clk_i);
      cyc(1);
      task_done_i = 1'b1;
      cyc(1);
      task_done_i = 1'b0;
    end
  end

  initial begin
    boot();
    go(3'h1, PSM_TL_SHALLOW_ENTRY, PSM_SHALLOW_SLEEP);
    chk_bit(serial_if_enable_o, 1'b1);
    chk_bit(power_save_allowed_o, 1'b1);
    chk_bit(comparators_active_o, 1'b1);
    chk_bit(thermal_mon_enable_o, 1'b0);
    power_button_in_n_i = 1'b0;
    cyc(4);
    chk_bit(power_button_to_host_n_o, 1'b0);
    power_button_in_n_i = 1'b1;
    cyc(4);
    go(3'h2, PSM_TL_SLEEP_ENTRY, PSM_SLEEP);
    chk_bit(serial_if_enable_o, 1'b0);
    chk_bit(comparators_active_o, 1'b1);
    go(3'h3, PSM_TL_DEEP_ENTRY, PSM_DEEP_SLEEP);
    chk_bit(serial_if_enable_o, 1'b0);
    go(3'h2, PSM_TL_DEEP_EXIT, PSM_SLEEP);
    go(3'h1, PSM_TL_SLEEP_EXIT, PSM_SHALLOW_SLEEP);
    go(3'h0, PSM_TL_SHALLOW_EXIT, PSM_ON);
    prst_n = 1'b0;
    cyc(4);
    chk_bit(serial_if_reset_o, 1'b1);
    chk_state(state_o, PSM_ON);
    prst_n = 1'b1;
    cyc(4);
    chk_bit(serial_if_reset_o, 1'b0);
    power_button_in_n_i = 1'b0;
    cyc(4);
    chk_bit(power_button_to_host_n_o, 1'b0);
    chk_bit(button_fault_o, 1'b0);
    cyc(12);
    chk_bit(button_fault_o, 1'b1);
    chk_bit(power_button_to_host_n_o, 1'b0);
    power_button_in_n_i = 1'b1;
    cyc(4);
    chk_bit(button_fault_o, 1'b0);
    shallow_sleep_used_i = 1'b0;
    go(3'h1, PSM_TL_SHALLOW_ENTRY, PSM_SHALLOW_SLEEP);
    go(3'h2, PSM_TL_SLEEP_ENTRY, PSM_SLEEP);
    go(3'h0, PSM_TL_SLEEP_EXIT, PSM_ON);
    shallow_sleep_used_i = 1'b1;
    go(3'h1, PSM_TL_SHALLOW_ENTRY, PSM_SHALLOW_SLEEP);
    go(3'h2, PSM_TL_SLEEP_ENTRY, PSM_SLEEP);
    go(3'h3, PSM_TL_DEEP_ENTRY, PSM_DEEP_SLEEP);
    chk_bit(power_save_allowed_o, 1'b1);
    go(3'h4, PSM_TL_COLD_OFF, PSM_STANDBY_ONLY);
    chk_bit(thermal_mon_enable_o, 1'b0);
    boot();
    thermal_critical_i = 1'b1;
    other_critical_i = 1'b1;
    #1;
    chk_bit(task_start_o, 1'b0);
    cyc(1);
    chk_bit(rail_force_off_o, 1'b1);
    wait_state(PSM_STANDBY_ONLY);
    thermal_critical_i = 1'b0;
    other_critical_i = 1'b0;
    boot();
    exp_q.push_back(PSM_TL_COLD_OFF);
    other_critical_i = 1'b1;
    wait_state(PSM_STANDBY_ONLY);
    other_critical_i = 1'b0;
    boot();
    go(3'h1, PSM_TL_SHALLOW_ENTRY, PSM_SHALLOW_SLEEP);
    exp_q.push_back(PSM_TL_COLD_OFF);
    enable_pin_mode_i = 1'b1;
    chip_enable_pin_i = 1'b0;
    wait_state(PSM_STANDBY_ONLY);
    supply_valid_i = 1'b0;
    #1;
    chk_bit(logic_reset_o, 1'b1);
    wait_state(PSM_NO_POWER);
    cyc(4);
    give_verdict();
  end
endmodule : soc_power_state_machine_tb_top
